/* logic/dual_mac_multiply_to_register.sv */
// Summary of operation
// - multiply two 16-bit operands, write saturated product to a register
// - accumulators are never touched by this operation
// - unit zero writes the low half or an even word, unit one the high half or an odd word
// - word results: even destination uses unit zero, odd uses unit one
// - word result with mixed-sign mode only on odd destinations
// - half results: low half unit zero, high half unit one; mixed high only
// - half results round per rounding select, except integer and truncate options
// - word results never round and ignore rounding select
// - default treats operands as signed fractions with one-bit left shift
// - unsigned fraction option: unsigned operands, no shift
// - signed integer option: signed integer operands, no shift
// - unsigned integer option: no shift, half destinations only
// - truncate options drop low bits, no rounding, half destinations only
// - scaling options double the result and saturate to 16 signed bits, or to 32 signed bits on word results
// - high-half extract: integer product saturated at 32, bits 31:16 kept
// - mixed mode: unit one multiplies signed by unsigned fraction, no shift
// - most negative fraction squared gives largest positive fraction
// - overflow flag set on saturation, cleared otherwise, every accepted operation; refused issues leave it unchanged
// - sticky overflow set with overflow, cleared by sticky_clear, otherwise holds
// - no other status flag is modified
// - every form is a 32-bit instruction
`timescale 1ns/1ps
module dual_mac_multiply_to_register (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // issue
    input wire logic issue_valid,
    input wire logic issue_long_form,
    input wire logic [mul_pkg::IDXW-1:0] dest_idx,
    input wire logic dest_is_word,
    input wire logic dest_is_high,
    input wire mul_pkg::opt_t option,
    input wire logic mixed_mode,
    input wire logic [mul_pkg::OPW-1:0] src_a,
    input wire logic [mul_pkg::OPW-1:0] src_b,
    // status control
    input wire logic rounding_mode_select,
    input wire logic sticky_clear,
    // register file write
    output logic wr_en,
    output logic [mul_pkg::IDXW-1:0] wr_idx,
    output logic [mul_pkg::WORDW-1:0] wr_data,
    output logic [1:0] wr_half_mask,
    // status
    output logic flags_update,
    output logic overflow_flag,
    output logic sticky_overflow_flag,
    output logic issue_refused
);

    typedef struct packed {
        logic wr_en;
        logic [mul_pkg::IDXW-1:0] wr_idx;
        logic [mul_pkg::WORDW-1:0] wr_data;
        logic [1:0] wr_half_mask;
        logic refused;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ****************************************
    // option classification
    // ****************************************
    function automatic logic opt_unsigned(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_UNSIGNED_FRACTION ||
               o == mul_pkg::OPT_UNSIGNED_INTEGER ||
               o == mul_pkg::OPT_UNSIGNED_TRUNCATE;
    endfunction

    function automatic logic opt_shift(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_DEFAULT ||
               o == mul_pkg::OPT_SIGNED_TRUNCATE ||
               o == mul_pkg::OPT_SCALED_FRACTION;
    endfunction

    function automatic logic opt_integer_low(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_SIGNED_INTEGER ||
               o == mul_pkg::OPT_UNSIGNED_INTEGER ||
               o == mul_pkg::OPT_SCALED_INTEGER;
    endfunction

    function automatic logic opt_truncate(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_SIGNED_TRUNCATE ||
               o == mul_pkg::OPT_UNSIGNED_TRUNCATE;
    endfunction

    function automatic logic opt_scaled(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_SCALED_FRACTION ||
               o == mul_pkg::OPT_SCALED_INTEGER;
    endfunction

    function automatic logic opt_word_ok(input mul_pkg::opt_t o);
        return o == mul_pkg::OPT_DEFAULT ||
               o == mul_pkg::OPT_UNSIGNED_FRACTION ||
               o == mul_pkg::OPT_SIGNED_INTEGER ||
               o == mul_pkg::OPT_SCALED_FRACTION ||
               o == mul_pkg::OPT_SCALED_INTEGER;
    endfunction

    // ****************************************
    // unit selection and legality
    // ****************************************
    logic unit_sel;
    logic legal;
    logic accept;

    always_comb begin
        if (dest_is_word) begin
            unit_sel = dest_idx[0];
        end else begin
            unit_sel = dest_is_high;
        end
        legal = issue_long_form;
        if (dest_is_word && !opt_word_ok(option)) begin
            legal = 1'h0;
        end
        if (mixed_mode && unit_sel != 1'(mul_pkg::UNIT_ONE)) begin
            legal = 1'h0;
        end
        accept = issue_valid && legal;
    end

    // ****************************************
    // multiply units
    // ****************************************
    mul_if unit_bus[mul_pkg::NUM_UNITS] ();
    logic signed [mul_pkg::WIDEW-1:0] unit_prod [mul_pkg::NUM_UNITS];

    for (genvar u = 0; u < mul_pkg::NUM_UNITS; u++) begin : g_unit
        logic mixed_here;
        logic active;

        assign active = unit_sel == 1'(u);
        assign mixed_here = mixed_mode && u == mul_pkg::UNIT_ONE;

        // idle unit sees zero operands so it does not toggle
        always_comb begin
            unit_bus[u].a = active ? src_a : '0;
            unit_bus[u].b = active ? src_b : '0;
            if (mixed_here) begin
                unit_bus[u].a_signed = 1'h1;
                unit_bus[u].b_signed = 1'h0;
                unit_bus[u].shift = 1'h0;
            end else begin
                unit_bus[u].a_signed = !opt_unsigned(option);
                unit_bus[u].b_signed = !opt_unsigned(option);
                unit_bus[u].shift = opt_shift(option);
            end
        end

        mac_unit u_mac (
            .port(unit_bus[u])
        );

        assign unit_prod[u] = unit_bus[u].prod;
    end

    // ****************************************
    // result formatting
    // ****************************************
    logic signed [mul_pkg::WIDEW-1:0] prod;
    logic signed [mul_pkg::WIDEW-1:0] scaled;
    logic [mul_pkg::WIDEW-1:0] rounded;
    logic res_unsigned;
    logic do_round;
    mul_pkg::sat_t sat_res;
    logic [mul_pkg::OPW-1:0] half_res;
    logic [mul_pkg::WORDW-1:0] result;
    logic [1:0] mask;

    always_comb begin
        prod = unit_sel ? unit_prod[mul_pkg::UNIT_ONE]
                        : unit_prod[mul_pkg::UNIT_ZERO];
        res_unsigned = opt_unsigned(option) && !mixed_mode;
        if (opt_scaled(option)) begin
            scaled = prod <<< 1;
        end else begin
            scaled = prod;
        end
        do_round = !dest_is_word && !opt_integer_low(option) &&
                   !opt_truncate(option);
        rounded = do_round ? mul_pkg::round_half(scaled,
                      rounding_mode_select == mul_pkg::RND_BIASED) : scaled;
        half_res = '0;
        if (dest_is_word) begin
            // the most negative square clamps here
            sat_res = mul_pkg::saturate(scaled, mul_pkg::WORDW,
                                        res_unsigned);
            result = sat_res.val[mul_pkg::WORDW-1:0];
            mask = mul_pkg::MASK_WORD;
        end else begin
            if (opt_integer_low(option)) begin
                sat_res = mul_pkg::saturate(scaled, mul_pkg::OPW,
                                            res_unsigned);
                half_res = sat_res.val[mul_pkg::OPW-1:0];
            end else begin
                sat_res = mul_pkg::saturate(signed'(rounded), mul_pkg::WORDW,
                                            res_unsigned);
                half_res = sat_res.val[mul_pkg::WORDW-1:mul_pkg::OPW];
            end
            if (unit_sel) begin
                result = {half_res, {mul_pkg::OPW{1'h0}}};
                mask = mul_pkg::MASK_HI;
            end else begin
                result = {{mul_pkg::OPW{1'h0}}, half_res};
                mask = mul_pkg::MASK_LO;
            end
        end
    end

    // ****************************************
    // register write stage
    // ****************************************
    always_comb begin
        state_d = state_q;
        state_d.wr_en = accept;
        state_d.refused = issue_valid && !legal;
        if (accept) begin
            // only the data register file is written
            state_d.wr_idx = dest_idx;
            state_d.wr_data = result;
            state_d.wr_half_mask = mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ovf_flags u_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .update(accept),
        .saturated(sat_res.hit),
        .sticky_clear(sticky_clear),
        .overflow_flag(overflow_flag),
        .sticky_overflow_flag(sticky_overflow_flag)
    );

    assign wr_en = state_q.wr_en;
    assign wr_idx = state_q.wr_idx;
    assign wr_data = state_q.wr_data;
    assign wr_half_mask = state_q.wr_half_mask;
    assign flags_update = state_q.wr_en;
    assign issue_refused = state_q.refused;

endmodule

/* logic/mul_pkg.sv */
package mul_pkg;

    // ****************************************
    // widths and constants
    // ****************************************
    localparam int OPW = 16;
    localparam int WORDW = 32;
    localparam int WIDEW = 36;
    localparam int IDXW = 3;
    localparam int UNIT_ZERO = 0;
    localparam int UNIT_ONE = 1;
    localparam int NUM_UNITS = 2;
    localparam logic [WIDEW-1:0] ROUND_BIAS = 36'h000008000;
    localparam logic [15:0] ROUND_TIE = 16'h8000;
    localparam int ROUND_LSB = 16;
    localparam logic [1:0] MASK_LO = 2'h1;
    localparam logic [1:0] MASK_HI = 2'h2;
    localparam logic [1:0] MASK_WORD = 2'h3;
    localparam logic RND_BIASED = 1'h1;

    // ****************************************
    // format options
    // ****************************************
    typedef enum logic [3:0] {
        OPT_DEFAULT,
        OPT_UNSIGNED_FRACTION,
        OPT_SIGNED_INTEGER,
        OPT_UNSIGNED_INTEGER,
        OPT_SIGNED_TRUNCATE,
        OPT_UNSIGNED_TRUNCATE,
        OPT_SCALED_FRACTION,
        OPT_SCALED_INTEGER,
        OPT_HIGH_HALF_EXTRACT
    } opt_t;

    typedef struct packed {
        logic hit;
        logic [WIDEW-1:0] val;
    } sat_t;

    // clamp a wide value to a signed or unsigned range of the given width
    function automatic sat_t saturate(input logic signed [WIDEW-1:0] v,
                                      input int bits, input logic uns);
        logic signed [WIDEW-1:0] maxv;
        logic signed [WIDEW-1:0] minv;
        sat_t r;
        if (uns) begin
            maxv = (36'sh1 <<< bits) - 36'sh1;
            minv = 36'sh0;
        end else begin
            maxv = (36'sh1 <<< (bits - 1)) - 36'sh1;
            minv = -(36'sh1 <<< (bits - 1));
        end
        r.hit = (v > maxv) || (v < minv);
        r.val = (v > maxv) ? maxv : ((v < minv) ? minv : v);
        return r;
    endfunction

    // round at the half-word boundary; unbiased rounds a tie to even
    function automatic logic [WIDEW-1:0] round_half(
            input logic [WIDEW-1:0] v, input logic biased);
        if (!biased && v[ROUND_LSB-1:0] == ROUND_TIE && !v[ROUND_LSB]) begin
            return v;
        end
        return v + ROUND_BIAS;
    endfunction

endpackage

/* logic/mul_if.sv */
`timescale 1ns/1ps
interface mul_if;
    logic [mul_pkg::OPW-1:0] a;
    logic [mul_pkg::OPW-1:0] b;
    logic a_signed;
    logic b_signed;
    logic shift;
    logic signed [mul_pkg::WIDEW-1:0] prod;

    modport unit(input a, input b, input a_signed, input b_signed,
                 input shift, output prod);
    modport issuer(output a, output b, output a_signed, output b_signed,
                   output shift, input prod);
endinterface

/* logic/mac_unit.sv */
`timescale 1ns/1ps
module mac_unit (
    // operands and product
    mul_if.unit port
);

    logic signed [mul_pkg::OPW:0] ext_a;
    logic signed [mul_pkg::OPW:0] ext_b;
    logic signed [2*mul_pkg::OPW+1:0] raw;
    logic signed [mul_pkg::WIDEW-1:0] wide;

    // ****************************************
    // 17x17 signed multiply, covers both signs
    // ****************************************
    always_comb begin
        ext_a = {port.a_signed & port.a[mul_pkg::OPW-1], port.a};
        ext_b = {port.b_signed & port.b[mul_pkg::OPW-1], port.b};
        raw = ext_a * ext_b;
        wide = mul_pkg::WIDEW'(raw);
        port.prod = port.shift ? (wide <<< 1) : wide;
    end

endmodule

/* logic/ovf_flags.sv */
`timescale 1ns/1ps
module ovf_flags (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // events
    input wire logic update,
    input wire logic saturated,
    input wire logic sticky_clear,
    // flags
    output logic overflow_flag,
    output logic sticky_overflow_flag
);

    typedef struct packed {
        logic ovf;
        logic sticky;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ****************************************
    // overflow and sticky overflow
    // ****************************************
    always_comb begin
        state_d = state_q;
        if (sticky_clear) begin
            state_d.sticky = 1'h0;
        end
        if (update) begin
            state_d.ovf = saturated;
            if (saturated) begin
                state_d.sticky = 1'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign overflow_flag = state_q.ovf;
    assign sticky_overflow_flag = state_q.sticky;

endmodule

/* tb/reg_file_model.sv */
`timescale 1ns/1ps
module reg_file_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // write port from the multiplier
    input wire logic wr_en,
    input wire logic [mul_pkg::IDXW-1:0] wr_idx,
    input wire logic [mul_pkg::WORDW-1:0] wr_data,
    input wire logic [1:0] wr_half_mask,
    // register contents
    output logic [7:0][mul_pkg::WORDW-1:0] regs_q
);
    // each lane is written only when its mask bit is set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regs_q <= '0;
        end else if (wr_en) begin
            if (wr_half_mask[0]) begin
                regs_q[wr_idx][15:0] <= wr_data[15:0];
            end
            if (wr_half_mask[1]) begin
                regs_q[wr_idx][31:16] <= wr_data[31:16];
            end
        end
    end
endmodule

/* tb/mul_properties.sv */
`timescale 1ns/1ps
module mul_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // issue
    input wire logic issue_valid,
    input wire logic issue_long_form,
    input wire logic [mul_pkg::IDXW-1:0] dest_idx,
    input wire logic dest_is_word,
    input wire logic dest_is_high,
    input wire mul_pkg::opt_t option,
    input wire logic mixed_mode,
    input wire logic sticky_clear,
    // results
    input wire logic wr_en,
    input wire logic [mul_pkg::IDXW-1:0] wr_idx,
    input wire logic [mul_pkg::WORDW-1:0] wr_data,
    input wire logic [1:0] wr_half_mask,
    input wire logic flags_update,
    input wire logic overflow_flag,
    input wire logic sticky_overflow_flag,
    input wire logic issue_refused
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ****************************************
    // answers
    // ****************************************
    property p_answer;
        issue_valid |=> wr_en != issue_refused;
    endproperty
    a_answer: assert property (p_answer)
        else $error("issue without a single answer");
    property p_quiet;
        !issue_valid |=> !wr_en && !issue_refused;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without issue");
    property p_pair;
        wr_en == flags_update;
    endproperty
    a_pair: assert property (p_pair)
        else $error("write and flag update apart");
    property p_idx;
        issue_valid |=> !wr_en || wr_idx == $past(dest_idx);
    endproperty
    a_idx: assert property (p_idx)
        else $error("wrong destination index");

    // ****************************************
    // unit selection and refusals
    // ****************************************
    property p_half_mask;
        issue_valid && !dest_is_word |=> !wr_en || wr_half_mask ==
            ($past(dest_is_high) ? mul_pkg::MASK_HI : mul_pkg::MASK_LO);
    endproperty
    a_half_mask: assert property (p_half_mask)
        else $error("half write in wrong lane");
    property p_word_mask;
        issue_valid && dest_is_word |=>
            !wr_en || wr_half_mask == mul_pkg::MASK_WORD;
    endproperty
    a_word_mask: assert property (p_word_mask)
        else $error("word write not full");
    property p_lo_clean;
        wr_en && wr_half_mask == mul_pkg::MASK_LO |->
            wr_data[31:16] == 16'h0000;
    endproperty
    a_lo_clean: assert property (p_lo_clean)
        else $error("low half write dirty");
    property p_short;
        issue_valid && !issue_long_form |=> issue_refused;
    endproperty
    a_short: assert property (p_short)
        else $error("short form accepted");
    property p_mix_unit;
        issue_valid && mixed_mode &&
            (dest_is_word ? !dest_idx[0] : !dest_is_high) |=> issue_refused;
    endproperty
    a_mix_unit: assert property (p_mix_unit)
        else $error("mixed mode on unit zero accepted");
    property p_word_opt;
        issue_valid && dest_is_word && option inside {
            mul_pkg::OPT_UNSIGNED_INTEGER, mul_pkg::OPT_SIGNED_TRUNCATE,
            mul_pkg::OPT_UNSIGNED_TRUNCATE, mul_pkg::OPT_HIGH_HALF_EXTRACT}
            |=> issue_refused;
    endproperty
    a_word_opt: assert property (p_word_opt)
        else $error("half only option accepted on word");

    // ****************************************
    // flags
    // ****************************************
    property p_ovf_hold;
        !wr_en |-> $stable(overflow_flag);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow moved without write");
    property p_sticky_set;
        wr_en && overflow_flag |-> sticky_overflow_flag;
    endproperty
    a_sticky_set: assert property (p_sticky_set)
        else $error("sticky not set with overflow");
    property p_sticky_keep;
        sticky_overflow_flag && !sticky_clear |=> sticky_overflow_flag;
    endproperty
    a_sticky_keep: assert property (p_sticky_keep)
        else $error("sticky lost");

    c_refused: cover property (issue_refused);
    c_ovf: cover property (wr_en && overflow_flag);
    c_high: cover property (wr_en && wr_half_mask == mul_pkg::MASK_HI);
endmodule

bind dual_mac_multiply_to_register mul_props mul_props_inst (
    .clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
    .issue_long_form(issue_long_form), .dest_idx(dest_idx),
    .dest_is_word(dest_is_word), .dest_is_high(dest_is_high),
    .option(option), .mixed_mode(mixed_mode), .sticky_clear(sticky_clear),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .wr_half_mask(wr_half_mask), .flags_update(flags_update),
    .overflow_flag(overflow_flag),
    .sticky_overflow_flag(sticky_overflow_flag),
    .issue_refused(issue_refused));

/* tb/test_dual_mac_multiply_to_register.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_dual_mac_multiply_to_register;
    localparam mul_pkg::opt_t O_DEF = mul_pkg::OPT_DEFAULT;
    localparam mul_pkg::opt_t O_UFR = mul_pkg::OPT_UNSIGNED_FRACTION;
    localparam mul_pkg::opt_t O_SIN = mul_pkg::OPT_SIGNED_INTEGER;
    localparam mul_pkg::opt_t O_UIN = mul_pkg::OPT_UNSIGNED_INTEGER;
    localparam mul_pkg::opt_t O_STR = mul_pkg::OPT_SIGNED_TRUNCATE;
    localparam mul_pkg::opt_t O_UTR = mul_pkg::OPT_UNSIGNED_TRUNCATE;
    localparam mul_pkg::opt_t O_SFR = mul_pkg::OPT_SCALED_FRACTION;
    localparam mul_pkg::opt_t O_SCI = mul_pkg::OPT_SCALED_INTEGER;
    localparam mul_pkg::opt_t O_HHX = mul_pkg::OPT_HIGH_HALF_EXTRACT;
    logic clk_sys = 1'h0, rst = 1'h1, issue_valid = 1'h0, lf = 1'h1;
    logic dest_is_word = 1'h0, dest_is_high = 1'h0, mixed_mode = 1'h0;
    logic rnd = 1'h0, sticky_clear = 1'h0, exp_ref = 1'h0;
    logic [2:0] dest_idx = 3'h0;
    logic [15:0] src_a = 16'h0000, src_b = 16'h0000;
    mul_pkg::opt_t option = mul_pkg::OPT_DEFAULT;
    logic wr_en, flags_update, ovf, sticky, issue_refused;
    logic [2:0] wr_idx;
    logic [31:0] wr_data, m;
    logic [1:0] wr_half_mask;
    logic [7:0][31:0] regs;
    int n_fail = 0, checked = 0;

    always #5 clk_sys = ~clk_sys;

    dual_mac_multiply_to_register dual_mac_multiply_to_register_inst (
        .clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
        .issue_long_form(lf), .dest_idx(dest_idx),
        .dest_is_word(dest_is_word), .dest_is_high(dest_is_high),
        .option(option), .mixed_mode(mixed_mode), .src_a(src_a),
        .src_b(src_b), .rounding_mode_select(rnd),
        .sticky_clear(sticky_clear), .wr_en(wr_en), .wr_idx(wr_idx),
        .wr_data(wr_data), .wr_half_mask(wr_half_mask),
        .flags_update(flags_update), .overflow_flag(ovf),
        .sticky_overflow_flag(sticky), .issue_refused(issue_refused));

    reg_file_model reg_file_model_inst (
        .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .wr_idx(wr_idx),
        .wr_data(wr_data), .wr_half_mask(wr_half_mask), .regs_q(regs));

    task automatic stop_test();
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // f holds {mixed, word, high half, biased rounding}
    task automatic run(input logic [3:0] f, input logic [2:0] idx,
            input mul_pkg::opt_t o, input logic [15:0] a, input logic [15:0] b,
            input logic [31:0] exp, input logic ov);
        @(negedge clk_sys);
        {mixed_mode, dest_is_word, dest_is_high, rnd} = f;
        dest_idx = idx;
        option = o;
        src_a = a;
        src_b = b;
        issue_valid = 1'h1;
        @(negedge clk_sys);
        issue_valid = 1'h0;
        `CHK("refused", exp_ref, issue_refused)
        `CHK("ovf", ov, ovf)
        `CHK("wr_en", ~exp_ref, wr_en)
        `CHK("flags_update", ~exp_ref, flags_update)
        if (!exp_ref) begin
            `CHK("data", exp, wr_data)
            `CHK("idx", idx, wr_idx)
            `CHK("mask", {f[2] | f[1], f[2] | ~f[1]}, wr_half_mask)
            m = f[2] ? 32'hFFFFFFFF : (f[1] ? 32'hFFFF0000 : 32'h0000FFFF);
            @(negedge clk_sys);
            `CHK("reg", exp, regs[idx] & m)
        end
    endtask

    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'h0;
        `CHK("reset ovf", 1'h0, ovf | sticky | wr_en)
        run(4'h1, 3'h0, O_DEF, 16'h4000, 16'h4000, 32'h00002000, 1'h0);
        run(4'h3, 3'h1, O_DEF, 16'h8000, 16'h8000, 32'h7FFF0000, 1'h1);
        run(4'h5, 3'h2, O_DEF, 16'h8000, 16'h8000, 32'h7FFFFFFF, 1'h1);
        run(4'h4, 3'h4, O_UFR, 16'hFFFF, 16'hFFFF, 32'hFFFE0001, 1'h0);
        `CHK("sticky", 1'h1, sticky)
        run(4'h4, 3'h5, O_SIN, 16'hFFFE, 16'h0003, 32'hFFFFFFFA, 1'h0);
        run(4'h0, 3'h6, O_SIN, 16'h0100, 16'h0100, 32'h00007FFF, 1'h1);
        run(4'h0, 3'h7, O_UIN, 16'h00FF, 16'h0100, 32'h0000FF00, 1'h0);
        run(4'h1, 3'h3, O_STR, 16'h0001, 16'h4000, 32'h00000000, 1'h0);
        run(4'h1, 3'h3, O_UTR, 16'hFFFF, 16'h7FFF, 32'h00007FFE, 1'h0);
        run(4'h2, 3'h0, O_SFR, 16'h6000, 16'h6000, 32'h7FFF0000, 1'h1);
        run(4'h0, 3'h2, O_SCI, 16'h0003, 16'h0005, 32'h0000001E, 1'h0);
        run(4'h4, 3'h0, O_SCI, 16'h0003, 16'h0005, 32'h0000001E, 1'h0);
        run(4'h1, 3'h4, O_HHX, 16'h1234, 16'h0100, 32'h00000012, 1'h0);
        run(4'h0, 3'h5, O_DEF, 16'h0001, 16'h4000, 32'h00000000, 1'h0);
        run(4'h1, 3'h5, O_DEF, 16'h0001, 16'h4000, 32'h00000001, 1'h0);
        run(4'h5, 3'h6, O_DEF, 16'h0001, 16'h4000, 32'h00008000, 1'h0);
        run(4'hC, 3'h3, O_DEF, 16'hFFFF, 16'hFFFF, 32'hFFFF0001, 1'h0);
        run(4'hA, 3'h7, O_SIN, 16'hFFFF, 16'hFFFF, 32'h80000000, 1'h1);
        exp_ref = 1'h1;
        lf = 1'h0;
        run(4'h0, 3'h0, O_DEF, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        lf = 1'h1;
        run(4'h4, 3'h0, O_UIN, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        run(4'h4, 3'h0, O_STR, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        run(4'h4, 3'h0, O_HHX, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        run(4'hC, 3'h2, O_DEF, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        run(4'h8, 3'h2, O_DEF, 16'h0001, 16'h0001, 32'h00000000, 1'h1);
        exp_ref = 1'h0;
        sticky_clear = 1'h1;
        @(negedge clk_sys);
        sticky_clear = 1'h0;
        @(negedge clk_sys);
        `CHK("sticky clr", 1'h0, sticky)
        `CHK("ovf kept", 1'h1, ovf)
        stop_test();
    end
endmodule
